/* File: vpf_pkg.sv */
`default_nettype none
package vpf_pkg;
	// sizes
	localparam int PORTS     = 8;
	localparam int PORT_W    = 3;
	localparam int VID_W     = 12;
	localparam int MGMT_W    = 13;
	localparam int GRP_W     = 3;
	localparam int TBL_DEPTH = 256;
	localparam int TBL_IW    = 8;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MGMT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TIDX  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_TDATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TCMD  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PORT  = 8'h40;
	localparam int PORT_SEL_LSB = 5;
	localparam int WORD_LSB     = 2;

	// field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_GVRP_BIT  = 2;
	localparam int STAT_MODE_LSB  = 0;
	localparam int STAT_GVRP_BIT  = 2;
	localparam int STAT_DREJ_BIT  = 3;
	localparam int TDATA_MEM_LSB  = 16;
	localparam int TCMD_WR_BIT    = 0;
	localparam int TCMD_DEL_BIT   = 1;
	localparam int TCMD_VALID_BIT = 31;
	localparam int PCFG_PVID_LSB  = 0;
	localparam int PCFG_TVID_LSB  = 12;
	localparam int PCFG_LINK_LSB  = 24;
	localparam int PCFG_GRP_LSB   = 26;

	typedef enum logic [1:0] {
		MODE_OFF  = 2'h0,
		MODE_PORT = 2'h1,
		MODE_TAG  = 2'h2
	} vpf_mode_t;

	typedef enum logic [1:0] {
		LINK_ACCESS = 2'h0,
		LINK_TRUNK  = 2'h1,
		LINK_HYBRID = 2'h2
	} vpf_link_t;

	// reset values
	localparam vpf_mode_t          MODE_RST = MODE_OFF;
	localparam vpf_link_t          LINK_RST = LINK_ACCESS;
	localparam logic [VID_W-1:0]   VID_DFLT = 12'h001;
	localparam logic [MGMT_W-1:0]  MGMT_RST = 13'h0000;
	localparam logic [GRP_W-1:0]   GRP_RST  = 3'h0;
endpackage
`default_nettype wire

/* File: vpf_vlan_table.sv */
`timescale 1ns/1ps
`default_nettype none
module vpf_vlan_table #(
	parameter int DEPTH = vpf_pkg::TBL_DEPTH,
	parameter int IW    = vpf_pkg::TBL_IW,
	parameter int NP    = vpf_pkg::PORTS,
	parameter int VW    = vpf_pkg::VID_W
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          reset_n,
	// update
	input  wire logic          wrEn,
	input  wire logic          delEn,
	input  wire logic          forceDflt,
	input  wire logic [IW-1:0] idx,
	input  wire logic [VW-1:0] wrVid,
	input  wire logic [NP-1:0] wrMembers,
	output logic               delReject,
	// lookups
	input  wire logic [VW-1:0] lookVid,
	output logic               lookHit,
	output logic [NP-1:0]      lookMembers,
	input  wire logic [VW-1:0] mgmtVid,
	output logic               mgmtHit,
	output logic [NP-1:0]      mgmtMembers,
	// readback
	output logic [VW-1:0]      rdVid,
	output logic [NP-1:0]      rdMembers,
	output logic               rdValid,
	output logic [NP-1:0]      dfltMembers
);
	import vpf_pkg::*;

	logic [VW-1:0]    vidReg [DEPTH];
	logic [VW-1:0]    vidNext [DEPTH];
	logic [NP-1:0]    memReg [DEPTH];
	logic [NP-1:0]    memNext [DEPTH];
	logic [DEPTH-1:0] validReg;
	logic [DEPTH-1:0] validNext;

	// lowest index wins when two entries carry one vid
	function automatic logic [NP:0] lookup(input logic [VW-1:0] key);
		logic [NP:0] r;
		r = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (validReg[i] && vidReg[i] == key)
				r = {1'b1, memReg[i]};
		end
		return r;
	endfunction

	assign delReject = delEn && idx == '0;

	always_comb begin
		vidNext = vidReg;
		memNext = memReg;
		validNext = validReg;
		{lookHit, lookMembers} = lookup(lookVid);
		{mgmtHit, mgmtMembers} = lookup(mgmtVid);
		if (delEn) begin
			if (idx != '0)
				validNext[idx] = 1'b0;
		end else if (wrEn) begin
			// entry zero keeps vid 1 so the default never vanishes
			if (idx != '0)
				vidNext[idx] = wrVid;
			memNext[idx] = wrMembers;
			validNext[idx] = 1'b1;
		end
		if (forceDflt) begin
			vidNext[0] = VID_DFLT;
			memNext[0] = '1;
			validNext[0] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				vidReg[i] <= '0;
				memReg[i] <= '0;
			end
			vidReg[0] <= VID_DFLT;
			memReg[0] <= '1;
			validReg <= {{(DEPTH-1){1'b0}}, 1'b1};
		end else begin
			vidReg <= vidNext;
			memReg <= memNext;
			validReg <= validNext;
		end
	end

	assign rdVid = vidReg[idx];
	assign rdMembers = memReg[idx];
	assign rdValid = validReg[idx];
	assign dfltMembers = memReg[0];

	property p_dflt_kept;
		@(posedge clock) disable iff (!reset_n)
		delEn && idx == '0 |=> validReg[0] && vidReg[0] == VID_DFLT;
	endproperty
	a_dflt_kept: assert property (p_dflt_kept)
		else $error("default vlan entry was removed");
endmodule
`default_nettype wire

/* File: vpf_filter.sv */
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vpf_filter (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          reset_n,
	// register port
	input  wire logic [vpf_pkg::ADDR_W-1:0]    regAddr,
	input  wire logic [vpf_pkg::DATA_W-1:0]    regWdata,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic [vpf_pkg::DATA_W-1:0]         regRdata,
	// frame decision request
	input  wire logic                          frmValid,
	input  wire logic [vpf_pkg::PORT_W-1:0]    frmPort,
	input  wire logic                          frmTagged,
	input  wire logic [vpf_pkg::VID_W-1:0]     frmVid,
	// frame decision answer
	output logic                               decValid,
	output logic [vpf_pkg::PORTS-1:0]          decFwdMask,
	output logic [vpf_pkg::PORTS-1:0]          decTagMask,
	output logic [vpf_pkg::VID_W-1:0]          decVid,
	output logic                               decDrop,
	output logic                               decMgmt,
	// registration protocol engine
	output logic                               gvrpActive
);
	import vpf_pkg::*;

	vpf_mode_t          modeReg, modeNext;
	logic               gvrpEnReg, gvrpEnNext;
	logic [MGMT_W-1:0]  mgmtVidReg, mgmtVidNext;
	logic               delRejReg, delRejNext;
	logic [TBL_IW-1:0]  tIdxReg, tIdxNext;
	logic [VID_W-1:0]   tVidReg, tVidNext;
	logic [PORTS-1:0]   tMemReg, tMemNext;
	logic [VID_W-1:0]   pvidReg [PORTS];
	logic [VID_W-1:0]   pvidNext [PORTS];
	logic [VID_W-1:0]   tvidReg [PORTS];
	logic [VID_W-1:0]   tvidNext [PORTS];
	vpf_link_t          linkReg [PORTS];
	vpf_link_t          linkNext [PORTS];
	logic [GRP_W-1:0]   grpReg [PORTS];
	logic [GRP_W-1:0]   grpNext [PORTS];
	logic               tblWr, tblDel, tblRej, forceDflt;
	logic [DATA_W-1:0]  rdataNext;
	logic               decValidNext, decDropNext, decMgmtNext;
	logic [PORTS-1:0]   decFwdNext, decTagNext;
	logic [VID_W-1:0]   decVidNext;
	logic [VID_W-1:0]   classVid;
	logic               inReject;
	logic [PORTS-1:0]   inHot, grpMask;
	logic               lookHit, mgmtHit, rdValid;
	logic [PORTS-1:0]   lookMem, mgmtMem, rdMem, dfltMem;
	logic [VID_W-1:0]   rdVid;
	vpf_link_t          inLink;

	function automatic logic isPortAddr(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:PORT_SEL_LSB] == OFS_PORT[ADDR_W-1:PORT_SEL_LSB];
	endfunction

	function automatic logic [PORT_W-1:0] portOf(input logic [ADDR_W-1:0] a);
		return a[WORD_LSB+:PORT_W];
	endfunction

	assign gvrpActive = gvrpEnReg && modeReg == MODE_TAG;
	assign inLink = linkReg[frmPort];
	assign inHot = {{(PORTS-1){1'b0}}, 1'b1} << frmPort;

	// configuration
	always_comb begin
		modeNext = modeReg;
		gvrpEnNext = gvrpEnReg;
		mgmtVidNext = mgmtVidReg;
		delRejNext = delRejReg;
		tIdxNext = tIdxReg;
		tVidNext = tVidReg;
		tMemNext = tMemReg;
		pvidNext = pvidReg;
		tvidNext = tvidReg;
		linkNext = linkReg;
		grpNext = grpReg;
		tblWr = 1'b0;
		tblDel = 1'b0;
		forceDflt = 1'b0;
		if (regWr) begin
			if (regAddr == OFS_CTRL) begin
				if (regWdata[CTRL_MODE_LSB+:2] inside {MODE_OFF, MODE_PORT, MODE_TAG})
					modeNext = vpf_mode_t'(regWdata[CTRL_MODE_LSB+:2]);
				gvrpEnNext = regWdata[CTRL_GVRP_BIT];
			end else if (regAddr == OFS_MGMT) begin
				mgmtVidNext = regWdata[MGMT_W-1:0];
			end else if (regAddr == OFS_STAT) begin
				if (regWdata[STAT_DREJ_BIT])
					delRejNext = 1'b0;
			end else if (regAddr == OFS_TIDX) begin
				tIdxNext = regWdata[TBL_IW-1:0];
			end else if (regAddr == OFS_TDATA) begin
				tVidNext = regWdata[VID_W-1:0];
				tMemNext = regWdata[TDATA_MEM_LSB+:PORTS];
			end else if (regAddr == OFS_TCMD) begin
				tblDel = regWdata[TCMD_DEL_BIT];
				tblWr = regWdata[TCMD_WR_BIT] && !regWdata[TCMD_DEL_BIT];
			end else if (isPortAddr(regAddr)) begin
				pvidNext[portOf(regAddr)] = regWdata[PCFG_PVID_LSB+:VID_W];
				tvidNext[portOf(regAddr)] = regWdata[PCFG_TVID_LSB+:VID_W];
				grpNext[portOf(regAddr)] = regWdata[PCFG_GRP_LSB+:GRP_W];
				if (regWdata[PCFG_LINK_LSB+:2] inside
						{LINK_ACCESS, LINK_TRUNK, LINK_HYBRID})
					linkNext[portOf(regAddr)] =
						vpf_link_t'(regWdata[PCFG_LINK_LSB+:2]);
			end
		end
		// a refusal in the clearing cycle still sets the flag
		if (tblRej)
			delRejNext = 1'b1;
		if (modeNext == MODE_TAG && modeReg != MODE_TAG) begin
			forceDflt = 1'b1;
			for (int p = 0; p < PORTS; p++)
				pvidNext[p] = VID_DFLT;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			modeReg <= MODE_RST;
			gvrpEnReg <= 1'b0;
			mgmtVidReg <= MGMT_RST;
			delRejReg <= 1'b0;
			tIdxReg <= '0;
			tVidReg <= '0;
			tMemReg <= '0;
			for (int p = 0; p < PORTS; p++) begin
				pvidReg[p] <= VID_DFLT;
				tvidReg[p] <= VID_DFLT;
				linkReg[p] <= LINK_RST;
				grpReg[p] <= GRP_RST;
			end
		end else begin
			modeReg <= modeNext;
			gvrpEnReg <= gvrpEnNext;
			mgmtVidReg <= mgmtVidNext;
			delRejReg <= delRejNext;
			tIdxReg <= tIdxNext;
			tVidReg <= tVidNext;
			tMemReg <= tMemNext;
			pvidReg <= pvidNext;
			tvidReg <= tvidNext;
			linkReg <= linkNext;
			grpReg <= grpNext;
		end
	end

	vpf_vlan_table #(
		.DEPTH (TBL_DEPTH),
		.IW    (TBL_IW),
		.NP    (PORTS),
		.VW    (VID_W)
	) u_table (
		.clock       (clock),
		.reset_n     (reset_n),
		.wrEn        (tblWr),
		.delEn       (tblDel),
		.forceDflt   (forceDflt),
		.idx         (tIdxReg),
		.wrVid       (tVidReg),
		.wrMembers   (tMemReg),
		.delReject   (tblRej),
		.lookVid     (classVid),
		.lookHit     (lookHit),
		.lookMembers (lookMem),
		.mgmtVid     (mgmtVidReg[VID_W-1:0]),
		.mgmtHit     (mgmtHit),
		.mgmtMembers (mgmtMem),
		.rdVid       (rdVid),
		.rdMembers   (rdMem),
		.rdValid     (rdValid),
		.dfltMembers (dfltMem)
	);

	// ingress classification
	always_comb begin
		classVid = frmTagged ? frmVid : pvidReg[frmPort];
		inReject = (inLink == LINK_ACCESS && frmTagged) ||
			(inLink == LINK_TRUNK && !frmTagged) ||
			(frmTagged && frmVid != tvidReg[frmPort]);
		grpMask = '0;
		// group zero is matched like any other group
		for (int e = 0; e < PORTS; e++)
			grpMask[e] = grpReg[e] == grpReg[frmPort];
	end

	// forwarding decision
	always_comb begin
		logic ok;
		ok = 1'b0;
		decValidNext = frmValid;
		decFwdNext = '0;
		decTagNext = '0;
		decVidNext = '0;
		decMgmtNext = 1'b0;
		if (frmValid) begin
			unique case (modeReg)
				MODE_OFF: decFwdNext = ~inHot;
				MODE_PORT: decFwdNext = grpMask & ~inHot;
				MODE_TAG: begin
					decVidNext = classVid;
					for (int e = 0; e < PORTS; e++) begin
						unique case (linkReg[e])
							LINK_ACCESS: ok = classVid == pvidReg[e];
							LINK_TRUNK: ok = classVid == tvidReg[e];
							default: ok = classVid == pvidReg[e] ||
								classVid == tvidReg[e];
						endcase
						decFwdNext[e] = !inReject && lookHit && lookMem[e] &&
							ok && !inHot[e];
						decTagNext[e] = decFwdNext[e] &&
							(linkReg[e] == LINK_TRUNK ||
							(linkReg[e] == LINK_HYBRID &&
							classVid == tvidReg[e]));
					end
					decMgmtNext = !inReject && mgmtVidReg != MGMT_RST &&
						{1'b0, classVid} == mgmtVidReg && mgmtHit &&
						mgmtMem[frmPort];
				end
				default: ;
			endcase
		end
		decDropNext = frmValid && decFwdNext == '0;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			decValid <= 1'b0;
			decFwdMask <= '0;
			decTagMask <= '0;
			decVid <= '0;
			decDrop <= 1'b0;
			decMgmt <= 1'b0;
		end else begin
			decValid <= decValidNext;
			decFwdMask <= decFwdNext;
			decTagMask <= decTagNext;
			decVid <= decVidNext;
			decDrop <= decDropNext;
			decMgmt <= decMgmtNext;
		end
	end

	// register readback, unmapped reads zero
	always_comb begin
		rdataNext = '0;
		if (regRd) begin
			if (regAddr == OFS_CTRL) begin
				rdataNext[CTRL_MODE_LSB+:2] = modeReg;
				rdataNext[CTRL_GVRP_BIT] = gvrpEnReg;
			end else if (regAddr == OFS_MGMT) begin
				rdataNext[MGMT_W-1:0] = mgmtVidReg;
			end else if (regAddr == OFS_STAT) begin
				rdataNext[STAT_MODE_LSB+:2] = modeReg;
				rdataNext[STAT_GVRP_BIT] = gvrpActive;
				rdataNext[STAT_DREJ_BIT] = delRejReg;
			end else if (regAddr == OFS_TIDX) begin
				rdataNext[TBL_IW-1:0] = tIdxReg;
			end else if (regAddr == OFS_TDATA) begin
				rdataNext[VID_W-1:0] = tVidReg;
				rdataNext[TDATA_MEM_LSB+:PORTS] = tMemReg;
			end else if (regAddr == OFS_TCMD) begin
				rdataNext[VID_W-1:0] = rdVid;
				rdataNext[TDATA_MEM_LSB+:PORTS] = rdMem;
				rdataNext[TCMD_VALID_BIT] = rdValid;
			end else if (isPortAddr(regAddr)) begin
				rdataNext[PCFG_PVID_LSB+:VID_W] = pvidReg[portOf(regAddr)];
				rdataNext[PCFG_TVID_LSB+:VID_W] = tvidReg[portOf(regAddr)];
				rdataNext[PCFG_LINK_LSB+:2] = linkReg[portOf(regAddr)];
				rdataNext[PCFG_GRP_LSB+:GRP_W] = grpReg[portOf(regAddr)];
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			regRdata <= '0;
		else
			regRdata <= rdataNext;
	end

	property p_port_group;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_PORT |=>
			(decFwdMask & ~$past(grpMask)) == '0 &&
			(decFwdMask & $past(inHot)) == '0;
	endproperty
	a_port_group: assert property (p_port_group)
		else $error("port mode forwarded outside the group");

	property p_port_notag;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_PORT |=> decTagMask == '0 && decVid == '0;
	endproperty
	a_port_notag: assert property (p_port_notag)
		else $error("port mode used a vlan tag");

	property p_mode_legal;
		@(posedge clock) disable iff (!reset_n)
		regWr && regAddr == OFS_CTRL && regWdata[1:0] == 2'h3 |=>
			modeReg == $past(modeReg);
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("illegal mode code was taken");

	property p_tag_entry;
		@(posedge clock) disable iff (!reset_n)
		modeReg == MODE_TAG && $past(modeReg) != MODE_TAG |->
			dfltMem == '1 && pvidReg[0] == VID_DFLT &&
			pvidReg[PORTS-1] == VID_DFLT;
	endproperty
	a_tag_entry: assert property (p_tag_entry)
		else $error("ports not placed in default vlan");

	property p_del_flag;
		@(posedge clock) disable iff (!reset_n)
		regWr && regAddr == OFS_TCMD && regWdata[TCMD_DEL_BIT] &&
			tIdxReg == '0 |=> delRejReg [*2];
	endproperty
	a_del_flag: assert property (p_del_flag)
		else $error("default delete not flagged");

	property p_gvrp_mode;
		@(posedge clock) disable iff (!reset_n)
		modeReg != MODE_TAG |-> !gvrpActive;
	endproperty
	a_gvrp_mode: assert property (p_gvrp_mode)
		else $error("gvrp active outside tag mode");

	property p_mgmt_off;
		@(posedge clock) disable iff (!reset_n)
		decMgmt |-> $past(mgmtVidReg) != MGMT_RST &&
			{1'b0, decVid} == $past(mgmtVidReg);
	endproperty
	a_mgmt_off: assert property (p_mgmt_off)
		else $error("management granted without a matching vid");

	property p_access_tagged;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_TAG && frmTagged &&
			inLink == LINK_ACCESS |=> decDrop && decFwdMask == '0;
	endproperty
	a_access_tagged: assert property (p_access_tagged)
		else $error("access port accepted a tagged frame");

	property p_trunk_untagged;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_TAG && !frmTagged &&
			inLink == LINK_TRUNK |=> decDrop;
	endproperty
	a_trunk_untagged: assert property (p_trunk_untagged)
		else $error("trunk port accepted an untagged frame");

	property p_untag_class;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_TAG && !frmTagged &&
			inLink != LINK_TRUNK |=> decVid == $past(pvidReg[frmPort]);
	endproperty
	a_untag_class: assert property (p_untag_class)
		else $error("untagged frame not given the port vid");

	property p_member_only;
		@(posedge clock) disable iff (!reset_n)
		frmValid && modeReg == MODE_TAG |=>
			(decFwdMask & ~$past(lookMem)) == '0 &&
			(decTagMask & ~decFwdMask) == '0;
	endproperty
	a_member_only: assert property (p_member_only)
		else $error("frame sent to a non member port");
endmodule
`default_nettype wire

/* File: vpf_station.sv */
`timescale 1ns/1ps
`default_nettype none
module vpf_station (
	// clock
	input  wire logic                  clock,
	// frame decision request
	output logic                       frmValid,
	output logic [vpf_pkg::PORT_W-1:0] frmPort,
	output logic                       frmTagged,
	output logic [vpf_pkg::VID_W-1:0]  frmVid
);
	import vpf_pkg::*;
	initial begin
		frmValid  = 1'b0;
		frmPort   = 3'h0;
		frmTagged = 1'b0;
		frmVid    = 12'h000;
	end
	// one frame per call; idle lines show the inverse, so no stale copy
	task automatic send(input logic [PORT_W-1:0] p, input logic t,
		input logic [VID_W-1:0] v);
		@(posedge clock);
		frmValid  <= 1'b1;
		frmPort   <= p;
		frmTagged <= t;
		frmVid    <= v;
		@(posedge clock);
		frmValid  <= 1'b0;
		frmPort   <= ~p;
		frmTagged <= ~t;
		frmVid    <= ~v;
	endtask
endmodule
`default_nettype wire

/* File: vpf_filter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module vpf_filter_test;
	import vpf_pkg::*;
	logic              clock;
	logic              reset_n;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata;
	logic              regWr;
	logic              regRd;
	logic [DATA_W-1:0] regRdata;
	logic              frmValid;
	logic [PORT_W-1:0] frmPort;
	logic              frmTagged;
	logic [VID_W-1:0]  frmVid;
	logic              decValid;
	logic [PORTS-1:0]  decFwdMask;
	logic [PORTS-1:0]  decTagMask;
	logic [VID_W-1:0]  decVid;
	logic              decDrop;
	logic              decMgmt;
	logic              gvrpActive;
	int                nErrors;
	int                samplesChecked;

	vpf_filter DUT (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .frmValid(frmValid), .frmPort(frmPort),
		.frmTagged(frmTagged), .frmVid(frmVid), .decValid(decValid),
		.decFwdMask(decFwdMask), .decTagMask(decTagMask), .decVid(decVid),
		.decDrop(decDrop), .decMgmt(decMgmt), .gvrpActive(gvrpActive));
	vpf_station src (.clock(clock), .frmValid(frmValid), .frmPort(frmPort),
		.frmTagged(frmTagged), .frmVid(frmVid));

	initial clock = 1'b0;
	always #25 clock = ~clock;

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] got,
		input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic done(input string n);
		$display("test %s done, mismatches so far %0d", n, nErrors);
	endtask
	function automatic logic [ADDR_W-1:0] pa(input int p);
		return OFS_PORT + ADDR_W'(4 * p);
	endfunction
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clock);
		regWr    <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input string name);
		@(posedge clock);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd   <= 1'b0;
		#1;
		chk(name, regRdata, e);
	endtask
	// drop is expected exactly when no egress port is left
	task automatic frm(input logic [PORT_W-1:0] p, input logic t,
		input logic [VID_W-1:0] v, input logic [PORTS-1:0] fwd,
		input logic [PORTS-1:0] tag, input logic [VID_W-1:0] cv,
		input logic mg);
		int k;
		src.send(p, t, v);
		k = 0;
		#1;
		while (decValid !== 1'b1 && k < 3) begin
			@(posedge clock);
			#1;
			k++;
		end
		if (decValid !== 1'b1) begin
			chk("decValid", {31'h0, decValid}, 32'h1); // answer due
			close_out();
		end
		chk("decision", {2'h0, decFwdMask, decTagMask, decVid, decDrop,
			decMgmt}, {2'h0, fwd, tag, cv, (fwd == 8'h00), mg});
	endtask

	initial begin
		reset_n        = 1'b0;
		regAddr        = 8'h00;
		regWdata       = 32'h0;
		regWr          = 1'b0;
		regRd          = 1'b0;
		nErrors        = 0;
		samplesChecked = 0;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		rd(OFS_CTRL, 32'h0, "ctrl"); // starts off
		rd(OFS_MGMT, 32'h0, "mgmt"); // access off
		rd(pa(0), 32'h0000_1001, "port0"); // access link
		rd(8'h3C, 32'h0, "unmapped");
		frm(3'h2, 1'b1, 12'h005, 8'hFB, 8'h00, 12'h000, 1'b0); // floods
		wr(OFS_CTRL, 32'h7);
		rd(OFS_CTRL, 32'h4, "ctrl"); // code 3 ignored
		chk("gvrp", {31'h0, gvrpActive}, 32'h0); // off mode
		done("reset");
		wr(OFS_CTRL, 32'h5);
		for (int i = 0; i < 4; i++) begin
			wr(pa(i), (i < 2) ? 32'h0400_1001 : 32'h0800_1005);
		end
		chk("gvrp", {31'h0, gvrpActive}, 32'h0); // port mode
		frm(3'h0, 1'b1, 12'h063, 8'h02, 8'h00, 12'h000, 1'b0); // group
		frm(3'h2, 1'b0, 12'h000, 8'h08, 8'h00, 12'h000, 1'b0); // group
		frm(3'h5, 1'b0, 12'h000, 8'hD0, 8'h00, 12'h000, 1'b0); // group zero
		done("port");
		wr(OFS_CTRL, 32'h6);
		rd(pa(3), 32'h0800_1001, "port3"); // pvid forced
		rd(OFS_STAT, 32'h6, "stat"); // gvrp live
		chk("gvrp", {31'h0, gvrpActive}, 32'h1); // engine on
		frm(3'h0, 1'b0, 12'h000, 8'hFE, 8'h00, 12'h001, 1'b0); // vid 1
		wr(OFS_TIDX, 32'h0);
		wr(OFS_TCMD, 32'h2);
		rd(OFS_STAT, 32'hE, "stat"); // delete refused
		rd(OFS_TCMD, 32'h80FF_0001, "entry0"); // entry kept
		wr(OFS_STAT, 32'h8);
		rd(OFS_STAT, 32'h6, "stat"); // flag cleared
		done("default");
		wr(OFS_TIDX, 32'hFF);
		wr(OFS_TDATA, 32'h001C_000A);
		wr(OFS_TCMD, 32'h1);
		rd(OFS_TCMD, 32'h801C_000A, "entry255"); // last entry
		wr(pa(2), 32'h0100_A001);
		wr(pa(3), 32'h0000_100A);
		wr(pa(4), 32'h0200_A001);
		frm(3'h2, 1'b1, 12'h00A, 8'h18, 8'h10, 12'h00A, 1'b0); // trunk
		frm(3'h3, 1'b0, 12'h000, 8'h14, 8'h14, 12'h00A, 1'b0); // tag
		frm(3'h3, 1'b1, 12'h00A, 8'h00, 8'h00, 12'h00A, 1'b0); // refused
		frm(3'h2, 1'b0, 12'h000, 8'h00, 8'h00, 12'h001, 1'b0); // refused
		frm(3'h4, 1'b1, 12'h00A, 8'h0C, 8'h04, 12'h00A, 1'b0); // tagged
		frm(3'h4, 1'b0, 12'h000, 8'hE3, 8'h00, 12'h001, 1'b0); // pvid
		frm(3'h0, 1'b0, 12'h000, 8'hF2, 8'h00, 12'h001, 1'b0); // skips ports 2 and 3
		done("links");
		wr(OFS_MGMT, 32'hA);
		frm(3'h3, 1'b0, 12'h000, 8'h14, 8'h14, 12'h00A, 1'b1); // member
		frm(3'h0, 1'b0, 12'h000, 8'hF2, 8'h00, 12'h001, 1'b0); // other vlan
		wr(OFS_MGMT, 32'h1000);
		rd(OFS_MGMT, 32'h1000, "mgmt"); // top bit
		frm(3'h3, 1'b0, 12'h000, 8'h14, 8'h14, 12'h00A, 1'b0); // no match
		done("mgmt");
		wr(pa(7), 32'h0300_2002);
		rd(pa(7), 32'h0000_2002, "port7"); // link code 3 ignored
		wr(OFS_TCMD, 32'h3);
		rd(OFS_TCMD, 32'h001C_000A, "entry255"); // delete wins
		done("codes");
		// mid-run reset must bring the mode back to off
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(OFS_CTRL, 32'h0, "ctrl"); // off again
		chk("gvrp", {31'h0, gvrpActive}, 32'h0); // off again
		done("rereset");
		close_out();
	end
endmodule
`default_nettype wire
